//--- sds_pkg.sv
// Summary of operation
// - Each conveyed bit is the received header bit XOR the value predicted for that bit.
// - The two conveyed samples of a cell feed a recursive descrambler, one each half cell.
// - The second sample of a cell waits 211 bit periods in a delay store before use.
// - Injections move the generator along a sequence advanced by 211 samples.
// - Each conveyed bit is checked against its prediction; the result and its valid are aligned by one-bit stores.
// - At the first strobe the conveyed bit XOR the stored receiver sample goes to the taps.
// - At the second strobe the receiver and conveyed bits are latched, summed and used at t+212.
// - At t+213 the receiver sample store takes the generator bit and holds it for a cell.
// - The generator implements x^31 + x^28 + 1.
package sds_pkg;
    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int SDS_GEN_W = 31;
    localparam int SDS_TAP_HI = 30;
    localparam int SDS_TAP_LO = 27;
    localparam int SDS_DELAY_BITS = 211;
    localparam int SDS_ADVANCE = 211;
    localparam logic [30:0] SDS_GEN_RST = 31'h7fffffff;
    localparam logic [3:0] SDS_LOCK_COUNT = 4'h8;
    localparam logic [3:0] SDS_ERR_LIMIT = 4'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SDS_HUNT = 2'b01,
        SDS_LOCK = 2'b10
    } sds_state_e;

    // Received stream and cell timing from the delineation logic
    typedef struct packed
    {
        logic rx_bit;
        logic pred_bit;
        logic hec8_stb;
        logic hec7_stb;
    } sds_cell_s;

    // One step of the generator
    function automatic logic [30:0] sds_step(input logic [30:0] s);
        sds_step = {s[29:0], s[SDS_TAP_HI] ^ s[SDS_TAP_LO]};
    endfunction : sds_step

    // Correction vector: unit state walked forward by the advance
    function automatic logic [30:0] sds_adv_vec();
        logic [30:0] v;
        v = 31'h00000001;
        for (int i = 0; i < SDS_ADVANCE; i++)
        begin
            v = sds_step(v);
        end
        sds_adv_vec = v;
    endfunction : sds_adv_vec
endpackage : sds_pkg

//--- sds_top.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Fixed-length delay store, one valid/bit pair per stage
// ------------------------------------------------------------
module sds_delay_store
    import sds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_vld,
    input wire logic in_bit,
    output logic out_vld,
    output logic out_bit
);
    logic [SDS_DELAY_BITS-1:0] vld_r;
    logic [SDS_DELAY_BITS-1:0] bit_r;
    logic [SDS_DELAY_BITS-1:0] vld_nxt;
    logic [SDS_DELAY_BITS-1:0] bit_nxt;

    // Shift chain, one generate stage per bit period
    genvar g;
    generate
        for (g = 0; g < SDS_DELAY_BITS; g++)
        begin : g_stage
            if (g == 0)
            begin : g_head
                assign vld_nxt[g] = in_vld;
                assign bit_nxt[g] = in_bit;
            end
            else
            begin : g_body
                assign vld_nxt[g] = vld_r[g-1];
                assign bit_nxt[g] = bit_r[g-1];
            end
        end
    endgenerate

    // Register the chain; cleared so no stale sample leaves after reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            vld_r <= '0;
            bit_r <= '0;
        end
        else
        begin
            vld_r <= vld_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign out_vld = vld_r[SDS_DELAY_BITS-1];
    assign out_bit = bit_r[SDS_DELAY_BITS-1];
endmodule : sds_delay_store

// ------------------------------------------------------------
// Sample descrambler synchroniser
// ------------------------------------------------------------
module sds_top
    import sds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire sds_cell_s cell_in,
    output logic prbs_bit,
    output logic scr_sync,
    output logic check_fail
);
    localparam logic [30:0] ADV_VEC = sds_adv_vec();

    logic conveyed_bit;
    logic early_sample_sum;
    logic mux_vld;
    logic mux_bit;
    logic dly_vld;
    logic dly_bit;
    logic [30:0] gen_r, gen_nxt;
    logic receiver_sample_store_r, receiver_sample_store_nxt;
    logic conveyed_sample_store_r, conveyed_sample_store_nxt;
    logic recv_cap_r, recv_cap_nxt;
    logic late_sample_sum_r, late_sample_sum_nxt;
    logic late_vld_r, late_vld_nxt;
    logic cap_pend_r, cap_pend_nxt;
    logic chk_vld_r, chk_vld_nxt;
    logic pred_store_r, pred_store_nxt;
    logic fail_r, fail_nxt;
    logic [3:0] good_r, good_nxt;
    logic [3:0] bad_r, bad_nxt;
    sds_state_e state_r, state_nxt;

    // ------------------------------------------------------------
    // Sample recovery and multiplexer
    // ------------------------------------------------------------
    // Predicted header bit removed from the received one
    assign conveyed_bit = cell_in.rx_bit ^ cell_in.pred_bit;
    assign early_sample_sum = conveyed_bit ^ receiver_sample_store_r;
    // Early sum at the first strobe, late sum when it leaves the store
    assign mux_vld = cell_in.hec8_stb | dly_vld;
    assign mux_bit = cell_in.hec8_stb ? early_sample_sum : dly_bit;

    // The late sum waits a full 211 bit periods, counted from the second strobe;
    // fed from the next values so that the latch adds no extra period
    sds_delay_store u_late_store
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_vld(late_vld_nxt),
        .in_bit(late_sample_sum_nxt),
        .out_vld(dly_vld),
        .out_bit(dly_bit)
    );

    // ------------------------------------------------------------
    // Sample stores and generator
    // ------------------------------------------------------------
    // A correction only lands on the half-cell instants
    always_comb
    begin
        gen_nxt = sds_step(gen_r);
        if (mux_vld && mux_bit)
        begin
            gen_nxt = sds_step(gen_r) ^ ADV_VEC;
        end
        conveyed_sample_store_nxt = conveyed_sample_store_r;
        recv_cap_nxt = recv_cap_r;
        late_vld_nxt = 1'b0;
        late_sample_sum_nxt = late_sample_sum_r;
        if (cell_in.hec7_stb)
        begin
            conveyed_sample_store_nxt = conveyed_bit;
            recv_cap_nxt = gen_r[SDS_TAP_HI];
            late_sample_sum_nxt = conveyed_bit ^ gen_r[SDS_TAP_HI];
            late_vld_nxt = 1'b1;
        end
        // One cycle after the late sum is used: t+213
        cap_pend_nxt = dly_vld;
        receiver_sample_store_nxt = receiver_sample_store_r;
        if (cap_pend_r)
        begin
            receiver_sample_store_nxt = gen_r[SDS_TAP_HI];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            gen_r <= SDS_GEN_RST;
            conveyed_sample_store_r <= 1'b0;
            recv_cap_r <= 1'b0;
            late_sample_sum_r <= 1'b0;
            late_vld_r <= 1'b0;
            cap_pend_r <= 1'b0;
            receiver_sample_store_r <= 1'b0;
        end
        else
        begin
            gen_r <= gen_nxt;
            conveyed_sample_store_r <= conveyed_sample_store_nxt;
            recv_cap_r <= recv_cap_nxt;
            late_sample_sum_r <= late_sample_sum_nxt;
            late_vld_r <= late_vld_nxt;
            cap_pend_r <= cap_pend_nxt;
            receiver_sample_store_r <= receiver_sample_store_nxt;
        end
    end

    // ------------------------------------------------------------
    // Verification and lock
    // ------------------------------------------------------------
    // The compare result and its valid sit one cycle in single-bit stores before the verdict,
    // so the verdict never races the generator update it caused
    always_comb
    begin
        chk_vld_nxt = mux_vld;
        pred_store_nxt = mux_vld ? mux_bit : 1'b0;
        fail_nxt = chk_vld_r & pred_store_r;
        good_nxt = good_r;
        bad_nxt = bad_r;
        state_nxt = state_r;
        if (chk_vld_r)
        begin
            if (pred_store_r)
            begin
                good_nxt = 4'h0;
                bad_nxt = (bad_r == 4'hf) ? bad_r : bad_r + 4'h1;
            end
            else
            begin
                bad_nxt = 4'h0;
                good_nxt = (good_r == 4'hf) ? good_r : good_r + 4'h1;
            end
        end
        unique case (state_r)
            SDS_HUNT:
            begin
                if (good_nxt >= SDS_LOCK_COUNT)
                begin
                    state_nxt = SDS_LOCK;
                end
            end
            SDS_LOCK:
            begin
                // A few stray bit errors do not drop lock
                if (bad_nxt >= SDS_ERR_LIMIT)
                begin
                    state_nxt = SDS_HUNT;
                end
            end
            default:
            begin
                state_nxt = SDS_HUNT;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            chk_vld_r <= 1'b0;
            pred_store_r <= 1'b0;
            fail_r <= 1'b0;
            good_r <= 4'h0;
            bad_r <= 4'h0;
            state_r <= SDS_HUNT;
        end
        else
        begin
            chk_vld_r <= chk_vld_nxt;
            pred_store_r <= pred_store_nxt;
            fail_r <= fail_nxt;
            good_r <= good_nxt;
            bad_r <= bad_nxt;
            state_r <= state_nxt;
        end
    end

    assign prbs_bit = gen_r[SDS_TAP_HI];
    assign scr_sync = (state_r == SDS_LOCK);
    assign check_fail = fail_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    conv_recover_a: assert property (cell_in.hec8_stb |-> mux_vld &&
        mux_bit == (cell_in.rx_bit ^ cell_in.pred_bit ^ receiver_sample_store_r))
        else $error("early sum not built from conveyed bit");
    late_select_a: assert property (cell_in.hec7_stb |-> ##211 (dly_vld && mux_vld))
        else $error("late sum not selected at t+212");
    late_hold_a: assert property (late_vld_r |-> ##210
        (dly_bit == $past(late_sample_sum_r, 210)))
        else $error("delay store lost the late sum");
    late_pair_a: assert property (cell_in.hec7_stb |=> late_vld_r &&
        recv_cap_r == $past(prbs_bit) &&
        late_sample_sum_r == (conveyed_sample_store_r ^ recv_cap_r))
        else $error("late sum not built from the latched pair");
    recv_store_a: assert property (cap_pend_r |=>
        receiver_sample_store_r == $past(prbs_bit))
        else $error("receiver store missed the t+213 sample");
    recv_hold_a: assert property (!cap_pend_r |=> $stable(receiver_sample_store_r))
        else $error("receiver store changed off its instant");
    gen_poly_a: assert property (!(mux_vld && mux_bit) |=>
        gen_r == sds_step($past(gen_r)))
        else $error("generator step wrong");
    gen_advance_a: assert property ((mux_vld && mux_bit) |=>
        gen_r == (sds_step($past(gen_r)) ^ ADV_VEC))
        else $error("correction not advanced");
    half_cell_a: assert property (mux_vld |-> (cell_in.hec8_stb || dly_vld))
        else $error("injection outside half-cell instants");
    check_align_a: assert property (mux_vld |-> ##2 (check_fail == $past(mux_bit, 2)))
        else $error("check verdict misaligned");

    lock_seen_c: cover property (state_r == SDS_HUNT ##1 state_r == SDS_LOCK);
    lock_lost_c: cover property (state_r == SDS_LOCK ##1 state_r == SDS_HUNT);
    late_used_c: cover property (cell_in.hec7_stb ##211 dly_vld);
    fail_seen_c: cover property (check_fail && scr_sync);
endmodule : sds_top

`default_nettype wire

//--- sds_cell_src.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Delineation-side model: strobes and header bits, one cell a call
// ------------------------------------------------------------
module sds_cell_src
    import sds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic prbs_bit,
    input wire logic check_fail,
    output var sds_cell_s cell_in
);
    localparam int CELL_LEN = 424;
    logic d2_model;

    // Idle start, no strobes before the first cell
    initial
    begin
        cell_in = '0;
        d2_model = 1'b0;
    end

    // Conveyed bits track the receiver generator unless an error is asked for
    task automatic run_cell(input logic err8, input logic err7, input logic pv8,
        input logic pv7, output logic f_e, output logic f_l, output logic f_x);
        f_e = 1'b0;
        f_l = 1'b0;
        f_x = 1'b0;
        for (int c = 0; c < CELL_LEN; c++)
        begin
            @(posedge ref_clk);
            #1;
            cell_in.hec8_stb = (c == 0);
            cell_in.hec7_stb = (c == 1);
            if (c == 0)
            begin
                cell_in.pred_bit = pv8;
                cell_in.rx_bit = d2_model ^ pv8 ^ err8;
            end
            else if (c == 1)
            begin
                cell_in.pred_bit = pv7;
                cell_in.rx_bit = prbs_bit ^ pv7 ^ err7;
            end
            else
            begin
                // Off the strobes the lines keep moving, never a stale value
                cell_in.rx_bit = ~cell_in.rx_bit;
                cell_in.pred_bit = ~cell_in.pred_bit;
            end
            if (c == 213)
                d2_model = prbs_bit;
            if (c == 2)
                f_e = check_fail;
            else if (c == 214)
                f_l = check_fail;
            else
                f_x = f_x | check_fail;
        end
    endtask : run_cell
endmodule : sds_cell_src

`default_nettype wire

//--- test_sample_descrambler_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the sample descrambler synchroniser
// ------------------------------------------------------------
module test_sample_descrambler_sync
    import sds_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    sds_cell_s cell_in;
    logic prbs_bit;
    logic scr_sync;
    logic check_fail;
    int bad_count = 0;
    int cmp_count = 0;
    logic fe, fl, fx;

    // 25 MHz bit clock
    always #20 ref_clk = ~ref_clk;

    sds_top u_sds_top (.ref_clk(ref_clk), .rst_n(rst_n), .cell_in(cell_in),
        .prbs_bit(prbs_bit), .scr_sync(scr_sync), .check_fail(check_fail));

    sds_cell_src u_sds_cell_src (.ref_clk(ref_clk), .prbs_bit(prbs_bit),
        .check_fail(check_fail), .cell_in(cell_in));

    task automatic check1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // One cell, all three fail slots judged
    task automatic cell_chk(input logic e8, input logic e7, input logic p8, input logic p7);
        u_sds_cell_src.run_cell(e8, e7, p8, p7, fe, fl, fx);
        check1("check_fail early", e8, fe);
        check1("check_fail late", e7, fl);
        check1("check_fail off slot", 1'b0, fx);
    endtask : cell_chk

    // Free-running generator must obey the recurrence, no checks without strobes
    task automatic test_poly();
        logic o [0:99];
        for (int n = 0; n < 100; n++)
        begin
            @(posedge ref_clk);
            #1;
            o[n] = prbs_bit;
            check1("check_fail idle", 1'b0, check_fail);
        end
        for (int n = 31; n < 100; n++)
            check1("prbs recurrence", o[n - 31] ^ o[n - 28], o[n]);
        $display("test_poly done");
    endtask : test_poly

    // Clean cells with every predicted-bit pair; lock must follow
    task automatic test_lock();
        u_sds_cell_src.run_cell(1'b0, 1'b0, 1'b0, 1'b0, fe, fl, fx);
        for (int k = 0; k < 6; k++)
            cell_chk(1'b0, 1'b0, k[0], k[1]);
        check1("scr_sync locked", 1'b1, scr_sync);
        $display("test_lock done");
    endtask : test_lock

    // Single errors keep lock, three in a row lose it, clean cells regain it
    task automatic test_errors();
        cell_chk(1'b1, 1'b0, 1'b1, 1'b0);
        check1("scr_sync after one", 1'b1, scr_sync);
        cell_chk(1'b0, 1'b1, 1'b0, 1'b1);
        cell_chk(1'b0, 1'b0, 1'b1, 1'b1);
        cell_chk(1'b1, 1'b1, 1'b0, 1'b1);
        check1("scr_sync after two", 1'b1, scr_sync);
        cell_chk(1'b1, 1'b0, 1'b1, 1'b0);
        check1("scr_sync after three", 1'b0, scr_sync);
        for (int k = 0; k < 5; k++)
            cell_chk(1'b0, 1'b0, k[1], k[0]);
        check1("scr_sync relocked", 1'b1, scr_sync);
        $display("test_errors done");
    endtask : test_errors

    // Main sequence: reset held 20 cycles, outputs checked inside it
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        check1("prbs_bit in reset", 1'b1, prbs_bit);
        check1("scr_sync in reset", 1'b0, scr_sync);
        check1("check_fail in reset", 1'b0, check_fail);
        rst_n = 1'b1;
        test_poly();
        test_lock();
        test_errors();
        report_and_stop();
    end

    // Watchdog, about three times the expected run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule : test_sample_descrambler_sync

`default_nettype wire
